// File: hw/core_ctrl_defs.svh
`ifndef CORE_CTRL_DEFS_SVH
`define CORE_CTRL_DEFS_SVH

`define IO_ADDR_SP_LOW 6'h3D
`define IO_ADDR_SP_HIGH 6'h3E
`define IO_ADDR_STATUS 6'h3F
`define IO_ADDR_MCU_CTRL 6'h35
`define IO_ADDR_FLAG_CLR 6'h1C
`define MCU_CTRL_VECTOR_TABLE_SELECT_BIT 1
`define STATUS_GIE_BIT 7
`define REGFILE_DATA_SPAN 16'h0020
`define PTR_X_INDEX 5'h1A
`define PTR_Y_INDEX 5'h1C
`define PTR_Z_INDEX 5'h1E
`define SRAM_LAST_ADDRESS 16'h08FF
`define BOOT_START_WORD 16'h3800
`define IRQ_ENTRY_CYCLES 4'h4
`define IRQ_WAKE_EXTRA 4'h4
`define RETURN_CYCLES 4'h4

`endif

// File: hw/core_ctrl_pkg.sv
package core_ctrl_pkg;
  typedef enum logic [2:0] {
    SP_HOLD, SP_PUSH1, SP_POP1, SP_PUSH2, SP_POP2
  } sp_op_t;
  typedef enum logic [1:0] {
    PTR_NONE, PTR_DISP, PTR_POSTINC, PTR_PREDEC
  } ptr_mode_t;
  typedef struct packed {
    logic [4:0] rd_a;
    logic [4:0] rd_b;
    logic wr8_en;
    logic wr16_en;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
  } rf_req_t;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] wide;
  } rf_rsp_t;
  typedef struct packed {
    ptr_mode_t mode;
    logic [1:0] sel;
    logic [5:0] disp;
  } ptr_req_t;
endpackage

// File: hw/regfile32.sv
`timescale 1ns/10ps
`include "core_ctrl_defs.svh"
module regfile32 import core_ctrl_pkg::*; #(
  parameter int NREG = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire rf_req_t req,
  input wire logic ds_wr,
  input wire logic [4:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  input wire logic ptr_upd,
  input wire logic [4:0] ptr_idx,
  input wire logic [15:0] ptr_val,
  output rf_rsp_t rsp,
  output logic [7:0] ds_rdata,
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z
);
  logic [7:0] regs_r [NREG];

  // Single-cycle reads; writes land at the clock edge
  always_comb begin
    rsp.a = regs_r[req.rd_a];
    rsp.b = regs_r[req.rd_b];
    rsp.wide = {regs_r[{req.rd_a[4:1], 1'b1}], regs_r[{req.rd_a[4:1], 1'b0}]};
    ds_rdata = regs_r[ds_addr];
    ptr_x = {regs_r[`PTR_X_INDEX + 5'd1], regs_r[`PTR_X_INDEX]};
    ptr_y = {regs_r[`PTR_Y_INDEX + 5'd1], regs_r[`PTR_Y_INDEX]};
    ptr_z = {regs_r[`PTR_Z_INDEX + 5'd1], regs_r[`PTR_Z_INDEX]};
  end

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gen_reg
      localparam logic [4:0] RI = 5'(g);
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          regs_r[g] <= 8'h00;
        end else if (clk_en) begin
          if (req.wr16_en && req.wr_addr[4:1] == RI[4:1]) begin
            regs_r[g] <= RI[0] ? req.wr_data[15:8] : req.wr_data[7:0];
          end else if (req.wr8_en && req.wr_addr == RI) begin
            regs_r[g] <= req.wr_data[7:0];
          end else if (ptr_upd && ptr_idx[4:1] == RI[4:1]) begin
            regs_r[g] <= RI[0] ? ptr_val[15:8] : ptr_val[7:0];
          end else if (ds_wr && ds_addr == RI) begin
            regs_r[g] <= ds_wdata;
          end
        end
      end
    end
  endgenerate
endmodule

// File: hw/irq_prio.sv
`timescale 1ns/10ps
module irq_prio #(
  parameter int NSRC = 8
) (
  input wire logic [NSRC-1:0] req,
  output logic any,
  output logic [$clog2(NSRC)-1:0] idx
);
  // Lowest index wins, matching the lowest vector address
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[$clog2(NSRC)-1:0];
      end
    end
  end
endmodule

// File: hw/core_ctrl.sv
// Overview of operation
// - Register file offers four read/write schemes
// - Registers mapped at lowest 32 data addresses
// - Top six registers form three pointers
// - Pointers support displacement, postincrement, predecrement
// - Stack byte push decrements, pop increments
// - Calls and interrupts push two bytes
// - Stack pointer bytes at I/O 0x3E/0x3D
// - Stack pointer resets to last SRAM address
// - Core runs from undivided clock
// - Two-operand ALU access in one cycle
// - Interrupt needs individual and global enable
// - Lower vector means higher priority
// - Select bit and fuse relocate vectors
// - Boot lock bits suppress interrupts by PC
// - Interrupt entry clears global enable
// - Return from interrupt sets global enable
// - Hardware clears flag when vectoring
// - Writing one clears an interrupt flag
// - Pending flags wait, served by priority
// - Level sources request only while present
// - One instruction runs after interrupt return
// - Status register not saved on interrupts
// - Global enable is status bit seven
// - Entry takes four cycles, plus wake
// - One instruction runs after enable-set
`timescale 1ns/10ps
`include "core_ctrl_defs.svh"
module core_ctrl import core_ctrl_pkg::*; #(
  parameter int NSRC = 8,
  parameter logic [NSRC-1:0] LEVEL_SRC = '0,
  parameter logic [15:0] SRAM_LAST = `SRAM_LAST_ADDRESS,
  parameter logic [15:0] BOOT_START = `BOOT_START_WORD
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire rf_req_t rf_req,
  input wire ptr_req_t ptr_req,
  input wire logic ds_wr,
  input wire logic [4:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire sp_op_t sp_op,
  input wire logic insn_done,
  input wire logic insn_return_from_interrupt,
  input wire logic insn_sei,
  input wire logic insn_cli,
  input wire logic asleep,
  input wire logic [15:0] pc,
  input wire logic [NSRC-1:0] src_event,
  input wire logic [NSRC-1:0] src_enable,
  input wire logic reset_vector_boot_fuse,
  input wire logic application_lock_bit,
  input wire logic bootsection_lock_bit,
  output rf_rsp_t rf_rsp,
  output logic [7:0] ds_rdata,
  output logic [15:0] ptr_addr,
  output logic [7:0] io_rdata,
  output logic [15:0] stack_ptr,
  output logic [7:0] status_reg,
  output logic [NSRC-1:0] irq_flags,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic irq_busy,
  output logic [15:0] reset_vector
);
  typedef enum logic [1:0] {IRQ_IDLE, IRQ_ENTRY, IRQ_RET} irq_state_t;

  localparam int IW = $clog2(NSRC);
  rf_rsp_t rf_rsp_c;
  logic [7:0] ds_rdata_c;
  logic [15:0] ptr_x, ptr_y, ptr_z, ptr_cur, ptr_nxt;
  logic ptr_upd;
  logic [4:0] ptr_idx;
  logic [15:0] sp_r, sp_nxt;
  logic [7:0] status_r;
  logic [7:0] mcu_control_reg_r;
  logic [NSRC-1:0] flag_r, pending, eligible;
  logic gie_wr;
  logic [7:0] gie_wdata;
  logic hold_one_r;
  logic [3:0] cnt_r;
  logic boot_suppress, any_req;
  logic [IW-1:0] win_idx;
  logic [IW-1:0] win_r;
  irq_state_t st_r;
  logic [NSRC-1:0] ev_s1_r, ev_s2_r;
  logic take_now, ret_start;

  // Event and level lines come from other logic: two-stage sync
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ev_s1_r <= '0;
      ev_s2_r <= '0;
    end else if (clk_en) begin
      ev_s1_r <= src_event;
      ev_s2_r <= ev_s1_r;
    end
  end

  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    case (sel)
      2'd0: ptr_base = `PTR_X_INDEX;
      2'd1: ptr_base = `PTR_Y_INDEX;
      default: ptr_base = `PTR_Z_INDEX;
    endcase
  endfunction

  assign ptr_idx = ptr_base(ptr_req.sel);
  assign ptr_cur = (ptr_req.sel == 2'd0) ? ptr_x :
                   (ptr_req.sel == 2'd1) ? ptr_y : ptr_z;

  // Indirect address and pointer update
  always_comb begin
    ptr_nxt = ptr_cur;
    ptr_upd = 1'b0;
    case (ptr_req.mode)
      PTR_POSTINC: begin
        ptr_nxt = ptr_cur + 16'h0001;
        ptr_upd = 1'b1;
      end
      PTR_PREDEC: begin
        ptr_nxt = ptr_cur - 16'h0001;
        ptr_upd = 1'b1;
      end
      default: begin
        ptr_nxt = ptr_cur;
        ptr_upd = 1'b0;
      end
    endcase
  end

  regfile32 u_rf (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .req(rf_req),
    .ds_wr(ds_wr),
    .ds_addr(ds_addr),
    .ds_wdata(ds_wdata),
    .ptr_upd(ptr_upd && clk_en),
    .ptr_idx(ptr_idx),
    .ptr_val(ptr_nxt),
    .rsp(rf_rsp_c),
    .ds_rdata(ds_rdata_c),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z)
  );

  // Register-file outputs registered (both operands in one cycle)
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rf_rsp <= '0;
      ds_rdata <= 8'h00;
      ptr_addr <= 16'h0000;
    end else if (clk_en) begin
      rf_rsp <= rf_rsp_c;
      ds_rdata <= ds_rdata_c;
      case (ptr_req.mode)
        PTR_DISP: ptr_addr <= ptr_cur + {10'h000, ptr_req.disp};
        PTR_PREDEC: ptr_addr <= ptr_nxt;
        default: ptr_addr <= ptr_cur;
      endcase
    end
  end

  // Stack pointer next value
  always_comb begin
    sp_nxt = sp_r;
    if (st_r == IRQ_ENTRY && cnt_r == 4'd1) begin
      sp_nxt = sp_r - 16'h0002;
    end else if (st_r == IRQ_RET && cnt_r == 4'd1) begin
      sp_nxt = sp_r + 16'h0002;
    end else begin
      case (sp_op)
        SP_PUSH1: sp_nxt = sp_r - 16'h0001;
        SP_POP1: sp_nxt = sp_r + 16'h0001;
        SP_PUSH2: sp_nxt = sp_r - 16'h0002;
        SP_POP2: sp_nxt = sp_r + 16'h0002;
        default: sp_nxt = sp_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sp_r <= SRAM_LAST;
    end else if (clk_en) begin
      if (io_wr && io_addr == `IO_ADDR_SP_LOW) begin
        sp_r <= {sp_r[15:8], io_wdata};
      end else if (io_wr && io_addr == `IO_ADDR_SP_HIGH) begin
        sp_r <= {io_wdata, sp_r[7:0]};
      end else begin
        sp_r <= sp_nxt;
      end
    end
  end

  // Status register: only the enable bit is touched by hardware
  assign gie_wr = io_wr && io_addr == `IO_ADDR_STATUS;
  assign gie_wdata = io_wdata;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_r <= 8'h00;
    end else if (clk_en) begin
      if (gie_wr) begin
        status_r <= gie_wdata;
      end
      if (take_now) begin
        status_r[`STATUS_GIE_BIT] <= 1'b0;
      end else if (st_r == IRQ_RET && cnt_r == 4'd1) begin
        status_r[`STATUS_GIE_BIT] <= 1'b1;
      end else if (insn_cli) begin
        status_r[`STATUS_GIE_BIT] <= 1'b0;
      end else if (insn_sei) begin
        status_r[`STATUS_GIE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mcu_control_reg_r <= 8'h00;
    end else if (clk_en && io_wr && io_addr == `IO_ADDR_MCU_CTRL) begin
      mcu_control_reg_r <= io_wdata;
    end
  end

  // Flags: set wins over clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NSRC; i++) begin
        if (LEVEL_SRC[i]) begin
          flag_r[i] <= 1'b0;
        end else if (ev_s2_r[i]) begin
          flag_r[i] <= 1'b1;
        end else if (take_now && win_idx == i[IW-1:0]) begin
          flag_r[i] <= 1'b0;
        end else if (io_wr && io_addr == `IO_ADDR_FLAG_CLR && io_wdata[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // Level sources look at the synchronised live condition, not at a flag
  assign pending = (flag_r & ~LEVEL_SRC) | (ev_s2_r & LEVEL_SRC);
  assign eligible = pending & src_enable;

  // Boot lock: suppress while PC sits in the locked section
  always_comb begin
    boot_suppress = 1'b0;
    if (application_lock_bit && pc < BOOT_START) begin
      boot_suppress = 1'b1;
    end
    if (bootsection_lock_bit && pc >= BOOT_START) begin
      boot_suppress = 1'b1;
    end
  end

  irq_prio #(.NSRC(NSRC)) u_prio (
    .req(eligible),
    .any(any_req),
    .idx(win_idx)
  );

  assign take_now = st_r == IRQ_IDLE && insn_done && any_req &&
                    status_r[`STATUS_GIE_BIT] && !hold_one_r &&
                    !boot_suppress && !insn_cli;
  assign ret_start = st_r == IRQ_IDLE && insn_return_from_interrupt && insn_done;

  // Hold-off of one instruction after return or enable-set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hold_one_r <= 1'b0;
    end else if (clk_en) begin
      if ((st_r == IRQ_RET && cnt_r == 4'd1) || insn_sei) begin
        hold_one_r <= 1'b1;
      end else if (insn_done) begin
        hold_one_r <= 1'b0;
      end
    end
  end

  // Entry/return sequencer; PC push happens during the count
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= IRQ_IDLE;
      cnt_r <= 4'd0;
      win_r <= '0;
    end else if (clk_en) begin
      case (st_r)
        IRQ_IDLE: begin
          if (take_now) begin
            st_r <= IRQ_ENTRY;
            win_r <= win_idx;
            cnt_r <= asleep ? `IRQ_ENTRY_CYCLES + `IRQ_WAKE_EXTRA
                            : `IRQ_ENTRY_CYCLES;
          end else if (ret_start) begin
            st_r <= IRQ_RET;
            cnt_r <= `RETURN_CYCLES;
          end
        end
        IRQ_ENTRY, IRQ_RET: begin
          if (cnt_r == 4'd1) begin
            st_r <= IRQ_IDLE;
          end
          cnt_r <= cnt_r - 4'd1;
        end
        default: st_r <= IRQ_IDLE;
      endcase
    end
  end

  // Vector addresses, two words per entry; relocation to boot start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_take <= 1'b0;
      irq_vector <= 16'h0000;
      reset_vector <= 16'h0000;
      irq_busy <= 1'b0;
    end else if (clk_en) begin
      irq_take <= take_now;
      irq_busy <= take_now || ret_start || (st_r != IRQ_IDLE && cnt_r != 4'd1);
      reset_vector <= reset_vector_boot_fuse ? BOOT_START : 16'h0000;
      if (take_now) begin
        irq_vector <= (mcu_control_reg_r[`MCU_CTRL_VECTOR_TABLE_SELECT_BIT] ?
                       BOOT_START : 16'h0000) +
                      {{(15 - IW){1'b0}}, win_idx, 1'b0} + 16'h0002;
      end
    end
  end

  // State registers shown as they stand, so writes are seen at once
  assign stack_ptr = sp_r;
  assign status_reg = status_r;
  assign irq_flags = flag_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (clk_en) begin
      if (io_rd && io_addr == `IO_ADDR_SP_LOW) begin
        io_rdata <= sp_r[7:0];
      end else if (io_rd && io_addr == `IO_ADDR_SP_HIGH) begin
        io_rdata <= sp_r[15:8];
      end else if (io_rd && io_addr == `IO_ADDR_STATUS) begin
        io_rdata <= status_r;
      end else if (io_rd && io_addr == `IO_ADDR_MCU_CTRL) begin
        io_rdata <= mcu_control_reg_r;
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end
  // every process runs on ref_clk, no divider
endmodule

// File: tb/core_ctrl_monitor.sv
`timescale 1ns/10ps
module core_ctrl_monitor import core_ctrl_pkg::*; #(
  parameter int NSRC = 8,
  parameter logic [15:0] SRAM_LAST = 16'h08FF,
  parameter logic [15:0] BOOT_START = 16'h3800
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic io_wr,
  input wire sp_op_t sp_op,
  input wire logic insn_done,
  input wire logic insn_return_from_interrupt,
  input wire logic reset_vector_boot_fuse,
  input wire logic [15:0] stack_ptr,
  input wire logic [7:0] status_reg,
  input wire logic irq_take,
  input wire logic irq_busy,
  input wire logic [15:0] reset_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [15:0] sp_take_r;
  logic quiet;
  assign quiet = clk_en && !io_wr && !irq_busy && !irq_take;
  // Stack pointer as it stood when entry began
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sp_take_r <= '0;
    end else if (irq_take) begin
      sp_take_r <= stack_ptr;
    end
  end
  sequence s_take;
    irq_take;
  endsequence
  sequence s_return_from_interrupt;
    insn_return_from_interrupt && insn_done;
  endsequence
  a_reset_sp_value: assert property ($fell(reset) |->
    stack_ptr == SRAM_LAST) else $error("stack pointer wrong after reset");
  a_push_one_byte: assert property (quiet && sp_op == SP_PUSH1 |=>
    stack_ptr == $past(stack_ptr) - 16'h0001) else $error("push1 step");
  a_pop_two_bytes: assert property (quiet && sp_op == SP_POP2 |=>
    stack_ptr == $past(stack_ptr) + 16'h0002) else $error("pop2 step");
  a_take_clears_gie: assert property (s_take |-> !status_reg[7])
    else $error("global enable kept on entry");
  a_take_needs_gie: assert property (s_take |-> $past(status_reg[7]))
    else $error("entry without global enable");
  a_entry_push_two: assert property (s_take |=> !irq_take[*3] ##[0:3]
    stack_ptr == sp_take_r - 16'h0002) else $error("entry push wrong");
  a_return_from_interrupt_sets_gie: assert property (s_return_from_interrupt |-> ##[1:5] status_reg[7])
    else $error("return left global enable clear");
  a_reset_vec_sel: assert property (1'b1 |=> reset_vector ==
    ($past(reset_vector_boot_fuse) ? BOOT_START : 16'h0000))
    else $error("reset vector wrong");
endmodule
bind core_ctrl core_ctrl_monitor #(.NSRC(NSRC), .SRAM_LAST(SRAM_LAST),
  .BOOT_START(BOOT_START)) mon (.ref_clk, .reset, .clk_en, .io_wr, .sp_op,
  .insn_done, .insn_return_from_interrupt, .reset_vector_boot_fuse, .stack_ptr, .status_reg,
  .irq_take, .irq_busy, .reset_vector);

// File: tb/irq_src_model.sv
`timescale 1ns/10ps
module irq_src_model #(
  parameter int NSRC = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [NSRC-1:0] fire,
  input wire logic [NSRC-1:0] hold,
  output logic [NSRC-1:0] src_event
);
  logic [NSRC-1:0] pulse_r;
  // One-cycle event strobe per request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulse_r <= '0;
    end else begin
      pulse_r <= fire;
    end
  end
  // Level condition present only while held
  assign src_event = pulse_r | hold;
endmodule

// File: tb/core_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module core_ctrl_tb import core_ctrl_pkg::*;;
  logic ref_clk = 0, reset = 1, clk_en = 1, ds_wr = 0, io_wr = 0, io_rd = 0;
  logic insn_done = 0, insn_return_from_interrupt = 0, insn_sei = 0, insn_cli = 0, fuse = 0;
  logic [4:0] ds_addr = 0;
  logic [7:0] ds_wdata = 0, io_wdata = 0, ds_rdata, io_rdata, status_reg;
  logic [5:0] io_addr = 0;
  logic [7:0] fire = 0, hold = 0, src_event, irq_flags, src_enable = 8'h8E;
  logic [15:0] ptr_addr, stack_ptr, irq_vector, reset_vector;
  logic irq_take, irq_busy;
  rf_req_t rf_req = '0;
  ptr_req_t ptr_req = '0;
  rf_rsp_t rf_rsp;
  sp_op_t sp_op = SP_HOLD;
  int n_errors = 0, checked = 0;
  sp_op_t row_op [5] = '{SP_PUSH1, SP_PUSH2, SP_POP1, SP_POP2, SP_HOLD};
  logic [15:0] row_sp [5] = '{16'h08FE, 16'h08FC, 16'h08FD, 16'h08FF,
    16'h08FF};
  core_ctrl #(.LEVEL_SRC(8'h80)) dut (.ref_clk, .reset, .clk_en, .rf_req,
    .ptr_req, .ds_wr, .ds_addr, .ds_wdata, .io_wr, .io_rd, .io_addr,
    .io_wdata, .sp_op, .insn_done, .insn_return_from_interrupt, .insn_sei, .insn_cli,
    .asleep(1'b0), .pc(16'h0000), .src_event, .src_enable,
    .reset_vector_boot_fuse(fuse), .application_lock_bit(1'b0),
    .bootsection_lock_bit(1'b0), .rf_rsp, .ds_rdata, .ptr_addr, .io_rdata,
    .stack_ptr, .status_reg, .irq_flags, .irq_take, .irq_vector, .irq_busy,
    .reset_vector);
  irq_src_model src (.ref_clk, .reset, .fire, .hold, .src_event);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic io_w(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk) {io_wr, io_addr, io_wdata} = {1'b1, a, d};
    @(negedge ref_clk) io_wr = 0;
  endtask
  task automatic io_chk(input logic [5:0] a, input logic [7:0] e);
    @(negedge ref_clk) {io_rd, io_addr} = {1'b1, a};
    @(negedge ref_clk) io_rd = 0;
    `CHK("io_rdata", e, io_rdata)
  endtask
  task automatic ptr_chk(ptr_mode_t m, logic [5:0] d, logic [15:0] e);
    @(negedge ref_clk) ptr_req = '{m, 2'd1, d};
    @(negedge ref_clk) ptr_req = '0;
    `CHK("ptr_addr", e, ptr_addr)
    tick(2);
  endtask
  task automatic fire_src(input int i);
    @(negedge ref_clk) fire[i] = 1;
    @(negedge ref_clk) fire = 0;
    tick(4);
  endtask
  task automatic do_insn(input logic t, input logic [15:0] v);
    @(negedge ref_clk) insn_done = 1;
    @(negedge ref_clk) insn_done = 0;
    `CHK("irq_take", t, irq_take)
    if (t) `CHK("irq_vector", v, irq_vector)
    if (t) `CHK("irq_busy", 1'b1, irq_busy)
    tick(6);
  endtask
  task automatic give_verdict;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk) reset = 0;
    `CHK("stack_ptr", 16'h08FF, stack_ptr)
    io_chk(6'h3E, 8'h08);
    io_chk(6'h01, 8'h00);
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk) sp_op = row_op[i];
      @(negedge ref_clk) sp_op = SP_HOLD;
      `CHK("stack_ptr", row_sp[i], stack_ptr)
    end
    io_w(6'h3E, 8'h04);
    io_w(6'h3D, 8'h80);
    `CHK("stack_ptr", 16'h0480, stack_ptr)
    io_chk(6'h3D, 8'h80);
    @(negedge ref_clk) rf_req = '{5'd0, 5'd0, 1'b1, 1'b0, 5'd5, 16'h00A5};
    @(negedge ref_clk) rf_req = '{5'd0, 5'd0, 1'b0, 1'b1, 5'd28, 16'h0134};
    @(negedge ref_clk) rf_req = '{5'd28, 5'd5, 1'b0, 1'b0, 5'd0, 16'h0};
    {ds_wr, ds_addr, ds_wdata} = {1'b1, 5'd3, 8'h5A};
    @(negedge ref_clk) ds_wr = 0;
    `CHK("rf_a", 8'h34, rf_rsp.a)
    `CHK("rf_b", 8'hA5, rf_rsp.b)
    `CHK("rf_wide", 16'h0134, rf_rsp.wide)
    rf_req.rd_a = 5'd3;
    @(negedge ref_clk);
    `CHK("rf_a", 8'h5A, rf_rsp.a)
    `CHK("ds_rdata", 8'h5A, ds_rdata)
    ptr_chk(PTR_DISP, 6'd5, 16'h0139);
    ptr_chk(PTR_POSTINC, 6'd0, 16'h0134);
    ptr_chk(PTR_DISP, 6'd0, 16'h0135);
    ptr_chk(PTR_PREDEC, 6'd0, 16'h0134);
    fire_src(2);
    do_insn(0, 0);
    `CHK("flag2", 1'b1, irq_flags[2])
    @(negedge ref_clk) insn_sei = 1;
    @(negedge ref_clk) insn_sei = 0;
    do_insn(0, 0);
    do_insn(1, 16'h0006);
    `CHK("gie", 1'b0, status_reg[7])
    `CHK("flag2", 1'b0, irq_flags[2])
    `CHK("stack_ptr", 16'h047E, stack_ptr)
    fire_src(3);
    fire_src(1);
    @(negedge ref_clk) hold[7] = 1;
    tick(4);
    hold = 0;
    do_insn(0, 0);
    `CHK("flags", 3'b101, irq_flags[3:1])
    @(negedge ref_clk) {insn_return_from_interrupt, insn_done} = 2'b11;
    @(negedge ref_clk) {insn_return_from_interrupt, insn_done} = 2'b00;
    tick(6);
    `CHK("gie", 1'b1, status_reg[7])
    `CHK("stack_ptr", 16'h0480, stack_ptr)
    do_insn(0, 0);
    do_insn(1, 16'h0004);
    io_w(6'h1C, 8'h08);
    `CHK("flag3", 1'b0, irq_flags[3])
    @(negedge ref_clk) insn_sei = 1;
    @(negedge ref_clk) insn_sei = 0;
    `CHK("gie", 1'b1, status_reg[7])
    @(negedge ref_clk) insn_cli = 1;
    @(negedge ref_clk) insn_cli = 0;
    `CHK("gie", 1'b0, status_reg[7])
    io_w(6'h35, 8'h02);
    fire_src(2);
    @(negedge ref_clk) insn_sei = 1;
    @(negedge ref_clk) insn_sei = 0;
    do_insn(0, 0);
    do_insn(1, 16'h3806);
    fuse = 1;
    tick(2);
    `CHK("reset_vector", 16'h3800, reset_vector)
    reset = 1;
    tick(2);
    reset = 0;
    `CHK("stack_ptr", 16'h08FF, stack_ptr)
    tick(2);
    give_verdict;
  end
endmodule
